// File: nlcr_pkg.sv
// Summary of operation
// - coefficients go live only on commit bit
// - either register's commit bit commits filter
// - 14-bit coefficients in bits 13:0, reset zero
// - bit 14 enables filters 1 to 3
// - filter 3 bit 14 selects low-pass
// - limiter timing bit 8 enables limiter
// - release code doubles from 750us, clamps
// - attack code doubles from 94us, clamps
// - limiter times scale with sample rate
// - threshold -1dB steps to -6dB clamp
// - bit 14 enables filter 0 too
// - gain lift 0 to 12dB, always applied
package nlcr_pkg;
   // register bus widths
   localparam int unsigned ADDR_W = 7;                // control port word address
   localparam int unsigned DATA_W = 16;               // control port data width
   localparam int unsigned COEF_W = 14;               // notch coefficient width
   localparam int unsigned FILT_N = 4;                // number of notch filters
   // register offsets
   localparam logic [6:0] OFS_NOTCH0_CTRL_COEF_A   = 7'h10;
   localparam logic [6:0] OFS_NOTCH0_COEF_B        = 7'h11;
   localparam logic [6:0] OFS_NOTCH1_CTRL_COEF_A   = 7'h12;
   localparam logic [6:0] OFS_NOTCH1_COEF_B        = 7'h13;
   localparam logic [6:0] OFS_NOTCH2_CTRL_COEF_A   = 7'h14;
   localparam logic [6:0] OFS_NOTCH2_COEF_B        = 7'h15;
   localparam logic [6:0] OFS_NOTCH3_CTRL_COEF_A   = 7'h16;
   localparam logic [6:0] OFS_NOTCH3_MODE_COEF_B   = 7'h17;
   localparam logic [6:0] OFS_LIMITER_ENABLE_TIMING = 7'h18;
   localparam logic [6:0] OFS_LIMITER_LEVEL_BOOST  = 7'h19;
   // field positions
   localparam int unsigned BIT_COMMIT    = 15;        // filter_commit_bit
   localparam int unsigned BIT_FILT_ON   = 14;        // enable / low-pass select
   localparam int unsigned BIT_LIM_ON    = 8;         // peak_limiter_on
   localparam int unsigned LSB_RELEASE   = 4;         // peak_limiter_release 7:4
   localparam int unsigned LSB_ATTACK    = 0;         // peak_limiter_attack 3:0
   localparam int unsigned LSB_THRESHOLD = 4;         // peak_limiter_threshold 6:4
   localparam int unsigned LSB_LIFT      = 0;         // peak_limiter_gain_lift 3:0
   // reset values
   localparam logic [13:0] RST_COEF      = 14'h0000;
   localparam logic [3:0]  RST_RELEASE   = 4'h3;
   localparam logic [3:0]  RST_ATTACK    = 4'h2;
   localparam logic [2:0]  RST_THRESHOLD = 3'h0;
   localparam logic [3:0]  RST_LIFT      = 4'h0;
   // limiter step times at the 44.1 kHz reference rate
   localparam int unsigned REF_RATE_HZ     = 44100;
   localparam int unsigned RELEASE_BASE_NS = 750000;  // 750 us per 6 dB at code 0
   localparam int unsigned ATTACK_BASE_NS  = 94000;   // 94 us per 6 dB at code 0
   // the same step times as counts of audio samples, so they follow the rate
   localparam int unsigned RELEASE_BASE_SMP =
      (RELEASE_BASE_NS / 1000) * REF_RATE_HZ / 1000000;
   localparam int unsigned ATTACK_BASE_SMP =
      (ATTACK_BASE_NS / 1000) * REF_RATE_HZ / 1000000;
   localparam logic [3:0] TIME_CODE_MAX   = 4'hb;     // codes above read as this
   localparam int unsigned STEP_W         = 17;       // width of a step count
   localparam logic [2:0] THRESHOLD_CLAMP = 3'h5;     // -6 dB and below
   localparam logic [3:0] LIFT_CLAMP      = 4'hc;     // +12 dB
endpackage

// File: nlcr_step_time.sv
`timescale 1ns/1ps
`default_nettype none
// turns a 4-bit limiter time code into samples per 6 dB step
module nlcr_step_time #(
   parameter int unsigned   BASE_SMP = 4,     // samples per step at code 0
   parameter logic [3:0]    RST_CODE = 4'h0   // code held by the register at reset
) (
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic [3:0]                  code,
   output logic [nlcr_pkg::STEP_W-1:0]      step_samples
);
   logic [3:0]                 eff_code;              // code after clamping
   logic [nlcr_pkg::STEP_W-1:0] next_step_samples;    // decoded count

   if (BASE_SMP == 0 || (BASE_SMP << 11) >= (1 << nlcr_pkg::STEP_W)) begin : g_bad
      $error("nlcr_step_time: base count does not fit");
   end

   // each code doubles the time; top codes all give the longest time
   always_comb begin
      eff_code = (code > nlcr_pkg::TIME_CODE_MAX) ? nlcr_pkg::TIME_CODE_MAX : code;
      // counted in samples so that the real time tracks the sample rate
      next_step_samples = nlcr_pkg::STEP_W'(BASE_SMP) << eff_code;
   end

   // registered so the limiter engine sees a clean value
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         step_samples <= nlcr_pkg::STEP_W'(BASE_SMP) << RST_CODE;
      end else begin
         step_samples <= next_step_samples;
      end
   end
endmodule
`default_nettype wire

// File: nlcr_notch_chan.sv
`timescale 1ns/1ps
`default_nettype none
// one notch filter: pending coefficients, working coefficients, control bits
module nlcr_notch_chan #(
   parameter bit HAS_MODE = 1'b0     // second register bit 14 is a mode select
) (
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic                         wr_first,     // write to first register
   input  wire logic                         wr_second,    // write to second register
   input  wire logic [nlcr_pkg::DATA_W-1:0]  wdata,
   output logic [nlcr_pkg::COEF_W-1:0]       pend_first,   // last written first coef
   output logic [nlcr_pkg::COEF_W-1:0]       pend_second,  // last written second coef
   output logic [nlcr_pkg::COEF_W-1:0]       work_first,   // coefficient in use
   output logic [nlcr_pkg::COEF_W-1:0]       work_second,  // coefficient in use
   output logic                              filt_on,      // filter applied
   output logic                              mode_sel,     // low-pass when set
   output logic                              commit_pulse  // one cycle after a commit
);
   logic [nlcr_pkg::COEF_W-1:0] next_pend_first;     // pending first after write
   logic [nlcr_pkg::COEF_W-1:0] next_pend_second;    // pending second after write
   logic [nlcr_pkg::COEF_W-1:0] next_work_first;     // working first after commit
   logic [nlcr_pkg::COEF_W-1:0] next_work_second;    // working second after commit
   logic                        next_filt_on;        // enable after write
   logic                        next_mode_sel;       // mode after write
   logic                        commit;              // commit bit written high

   // decode a write into the pending set and control bits
   always_comb begin
      next_pend_first  = pend_first;
      next_pend_second = pend_second;
      next_filt_on     = filt_on;
      next_mode_sel    = mode_sel;
      if (wr_first) begin
         next_pend_first = wdata[nlcr_pkg::COEF_W-1:0];
         next_filt_on    = wdata[nlcr_pkg::BIT_FILT_ON];
      end
      if (wr_second) begin
         next_pend_second = wdata[nlcr_pkg::COEF_W-1:0];
         // bit 14 is reserved unless this filter has a mode select
         next_mode_sel = HAS_MODE ? wdata[nlcr_pkg::BIT_FILT_ON] : 1'b0;
      end
      // commit from either register, including the value written with it
      commit = (wr_first | wr_second) & wdata[nlcr_pkg::BIT_COMMIT];
      next_work_first  = commit ? next_pend_first  : work_first;
      next_work_second = commit ? next_pend_second : work_second;
   end

   // register everything; all coefficients start at zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pend_first   <= nlcr_pkg::RST_COEF;
         pend_second  <= nlcr_pkg::RST_COEF;
         work_first   <= nlcr_pkg::RST_COEF;
         work_second  <= nlcr_pkg::RST_COEF;
         filt_on      <= 1'b0;
         mode_sel     <= 1'b0;
         commit_pulse <= 1'b0;
      end else begin
         pend_first   <= next_pend_first;
         pend_second  <= next_pend_second;
         work_first   <= next_work_first;
         work_second  <= next_work_second;
         filt_on      <= next_filt_on;
         mode_sel     <= next_mode_sel;
         commit_pulse <= commit;
      end
   end
endmodule
`default_nettype wire

// File: nlcr_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// notch filter and playback limiter configuration bank
// registers are written and read through a plain word port that the serial
// control interface drives; this bank only holds and decodes the values
module nlcr_config_regs (
   input  wire logic                         clk,
   input  wire logic                         reset,
   // register port from the serial control interface
   input  wire logic                         reg_wr,       // write strobe, one cycle
   input  wire logic [nlcr_pkg::ADDR_W-1:0]  reg_addr,     // word address
   input  wire logic [nlcr_pkg::DATA_W-1:0]  reg_wdata,    // write data
   output logic [nlcr_pkg::DATA_W-1:0]       reg_rdata,    // read data, next cycle
   output logic                              reg_hit,      // address is in this bank
   // notch filter 0
   output logic [nlcr_pkg::COEF_W-1:0]       filt0_coef_first,
   output logic [nlcr_pkg::COEF_W-1:0]       filt0_coef_second,
   output logic                              filt0_on,
   output logic                              filt0_commit,
   // notch filter 1
   output logic [nlcr_pkg::COEF_W-1:0]       filt1_coef_first,
   output logic [nlcr_pkg::COEF_W-1:0]       filt1_coef_second,
   output logic                              filt1_on,
   output logic                              filt1_commit,
   // notch filter 2
   output logic [nlcr_pkg::COEF_W-1:0]       filt2_coef_first,
   output logic [nlcr_pkg::COEF_W-1:0]       filt2_coef_second,
   output logic                              filt2_on,
   output logic                              filt2_commit,
   // notch filter 3
   output logic [nlcr_pkg::COEF_W-1:0]       filt3_coef_first,
   output logic [nlcr_pkg::COEF_W-1:0]       filt3_coef_second,
   output logic                              filt3_on,
   output logic                              filt3_commit,
   output logic                              filt3_lowpass_sel,
   // playback limiter
   output logic                              peak_limiter_on,
   output logic [3:0]                        peak_limiter_release,
   output logic [3:0]                        peak_limiter_attack,
   output logic [nlcr_pkg::STEP_W-1:0]       release_step_samples,
   output logic [nlcr_pkg::STEP_W-1:0]       attack_step_samples,
   output logic [2:0]                        peak_limiter_threshold,
   output logic [2:0]                        threshold_db_below,   // 1..6 dB below full
   output logic [3:0]                        peak_limiter_gain_lift,
   output logic [3:0]                        gain_lift_db          // 0..12 dB
);
   localparam int unsigned FN = nlcr_pkg::FILT_N;
   localparam int unsigned CW = nlcr_pkg::COEF_W;

   // per-filter write strobes
   logic [FN-1:0]  wr_first;                  // write to first register of filter
   logic [FN-1:0]  wr_second;                 // write to second register of filter
   // per-filter state from the channels
   logic [CW-1:0]  pend_first  [FN];          // readback of first coefficient
   logic [CW-1:0]  pend_second [FN];          // readback of second coefficient
   logic [CW-1:0]  work_first  [FN];          // coefficient in use
   logic [CW-1:0]  work_second [FN];          // coefficient in use
   logic [FN-1:0]  on_bits;                   // enable bit per filter
   logic [FN-1:0]  mode_bits;                 // mode bit per filter
   logic [FN-1:0]  commit_bits;               // commit pulse per filter

   // limiter register fields
   logic           lim_on;                    // limiter enable
   logic [3:0]     lim_release;               // release code
   logic [3:0]     lim_attack;                // attack code
   logic [2:0]     lim_threshold;             // threshold code
   logic [3:0]     lim_lift;                  // gain lift code
   logic           next_lim_on;
   logic [3:0]     next_lim_release;
   logic [3:0]     next_lim_attack;
   logic [2:0]     next_lim_threshold;
   logic [3:0]     next_lim_lift;
   logic [2:0]     next_threshold_db_below;
   logic [3:0]     next_gain_lift_db;
   // readback
   logic [nlcr_pkg::DATA_W-1:0] next_reg_rdata;
   logic                        next_reg_hit;
   logic                        addr_notch;   // address inside the notch range
   logic [1:0]                  filt_index;   // filter addressed
   logic                        filt_second;  // second register of the pair

   // notch range decode: pairs of words from the first notch register upward
   always_comb begin
      addr_notch = (reg_addr >= nlcr_pkg::OFS_NOTCH0_CTRL_COEF_A) &&
                   (reg_addr <= nlcr_pkg::OFS_NOTCH3_MODE_COEF_B);
      filt_index  = reg_addr[2:1];
      filt_second = reg_addr[0];
   end

   // one channel per filter; only filter 3 has a mode select
   for (genvar i = 0; i < FN; i++) begin : g_filt
      // steer the write strobe to the addressed register of this filter
      always_comb begin
         wr_first[i]  = reg_wr && addr_notch && (filt_index == 2'(i)) && !filt_second;
         wr_second[i] = reg_wr && addr_notch && (filt_index == 2'(i)) && filt_second;
      end

      nlcr_notch_chan #(
         .HAS_MODE (i == FN - 1)
      ) u_chan (
         .clk          (clk),
         .reset        (reset),
         .wr_first     (wr_first[i]),
         .wr_second    (wr_second[i]),
         .wdata        (reg_wdata),
         .pend_first   (pend_first[i]),
         .pend_second  (pend_second[i]),
         .work_first   (work_first[i]),
         .work_second  (work_second[i]),
         .filt_on      (on_bits[i]),
         .mode_sel     (mode_bits[i]),
         .commit_pulse (commit_bits[i])
      );
   end

   // fan the channel state out to named ports
   always_comb begin
      filt0_coef_first  = work_first[0];
      filt0_coef_second = work_second[0];
      filt0_on          = on_bits[0];
      filt0_commit      = commit_bits[0];
      filt1_coef_first  = work_first[1];
      filt1_coef_second = work_second[1];
      filt1_on          = on_bits[1];
      filt1_commit      = commit_bits[1];
      filt2_coef_first  = work_first[2];
      filt2_coef_second = work_second[2];
      filt2_on          = on_bits[2];
      filt2_commit      = commit_bits[2];
      filt3_coef_first  = work_first[3];
      filt3_coef_second = work_second[3];
      filt3_on          = on_bits[3];
      filt3_commit      = commit_bits[3];
      filt3_lowpass_sel = mode_bits[3];
   end

   // limiter register writes; bits outside the fields are dropped
   always_comb begin
      next_lim_on        = lim_on;
      next_lim_release   = lim_release;
      next_lim_attack    = lim_attack;
      next_lim_threshold = lim_threshold;
      next_lim_lift      = lim_lift;
      if (reg_wr && reg_addr == nlcr_pkg::OFS_LIMITER_ENABLE_TIMING) begin
         next_lim_on      = reg_wdata[nlcr_pkg::BIT_LIM_ON];
         next_lim_release = reg_wdata[nlcr_pkg::LSB_RELEASE +: 4];
         next_lim_attack  = reg_wdata[nlcr_pkg::LSB_ATTACK +: 4];
      end
      if (reg_wr && reg_addr == nlcr_pkg::OFS_LIMITER_LEVEL_BOOST) begin
         next_lim_threshold = reg_wdata[nlcr_pkg::LSB_THRESHOLD +: 3];
         next_lim_lift      = reg_wdata[nlcr_pkg::LSB_LIFT +: 4];
      end
   end

   // decode threshold and lift from the values about to be held
   always_comb begin
      // -1 dB at code 0, one dB per step, all top codes at -6 dB
      if (next_lim_threshold >= nlcr_pkg::THRESHOLD_CLAMP) begin
         next_threshold_db_below = nlcr_pkg::THRESHOLD_CLAMP + 3'h1;
      end else begin
         next_threshold_db_below = next_lim_threshold + 3'h1;
      end
      // reserved lift codes are held at the top legal step
      if (next_lim_lift > nlcr_pkg::LIFT_CLAMP) begin
         next_gain_lift_db = nlcr_pkg::LIFT_CLAMP;
      end else begin
         next_gain_lift_db = next_lim_lift;
      end
   end

   // limiter register state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lim_on             <= 1'b0;
         lim_release        <= nlcr_pkg::RST_RELEASE;
         lim_attack         <= nlcr_pkg::RST_ATTACK;
         lim_threshold      <= nlcr_pkg::RST_THRESHOLD;
         lim_lift           <= nlcr_pkg::RST_LIFT;
         threshold_db_below <= nlcr_pkg::RST_THRESHOLD + 3'h1;
         gain_lift_db       <= nlcr_pkg::RST_LIFT;
      end else begin
         lim_on             <= next_lim_on;
         lim_release        <= next_lim_release;
         lim_attack         <= next_lim_attack;
         lim_threshold      <= next_lim_threshold;
         lim_lift           <= next_lim_lift;
         threshold_db_below <= next_threshold_db_below;
         gain_lift_db       <= next_gain_lift_db;
      end
   end

   // raw limiter fields out; the lift acts whether or not the limiter runs
   always_comb begin
      peak_limiter_on        = lim_on;
      peak_limiter_release   = lim_release;
      peak_limiter_attack    = lim_attack;
      peak_limiter_threshold = lim_threshold;
      peak_limiter_gain_lift = lim_lift;
   end

   // release time per 6 dB step, counted in samples
   nlcr_step_time #(
      .BASE_SMP (nlcr_pkg::RELEASE_BASE_SMP),
      .RST_CODE (nlcr_pkg::RST_RELEASE)
   ) u_release (
      .clk          (clk),
      .reset        (reset),
      .code         (lim_release),
      .step_samples (release_step_samples)
   );

   // attack time per 6 dB step, counted in samples
   nlcr_step_time #(
      .BASE_SMP (nlcr_pkg::ATTACK_BASE_SMP),
      .RST_CODE (nlcr_pkg::RST_ATTACK)
   ) u_attack (
      .clk          (clk),
      .reset        (reset),
      .code         (lim_attack),
      .step_samples (attack_step_samples)
   );

   // readback of the addressed word; commit bits and reserved bits read zero
   always_comb begin
      next_reg_rdata = '0;
      next_reg_hit   = 1'b1;
      if (addr_notch) begin
         if (!filt_second) begin
            next_reg_rdata[CW-1:0]               = pend_first[filt_index];
            next_reg_rdata[nlcr_pkg::BIT_FILT_ON] = on_bits[filt_index];
         end else begin
            next_reg_rdata[CW-1:0]               = pend_second[filt_index];
            next_reg_rdata[nlcr_pkg::BIT_FILT_ON] = mode_bits[filt_index];
         end
      end else if (reg_addr == nlcr_pkg::OFS_LIMITER_ENABLE_TIMING) begin
         next_reg_rdata[nlcr_pkg::BIT_LIM_ON]        = lim_on;
         next_reg_rdata[nlcr_pkg::LSB_RELEASE +: 4]  = lim_release;
         next_reg_rdata[nlcr_pkg::LSB_ATTACK +: 4]   = lim_attack;
      end else if (reg_addr == nlcr_pkg::OFS_LIMITER_LEVEL_BOOST) begin
         next_reg_rdata[nlcr_pkg::LSB_THRESHOLD +: 3] = lim_threshold;
         next_reg_rdata[nlcr_pkg::LSB_LIFT +: 4]      = lim_lift;
      end else begin
         // not in this bank: read zero, flag the miss
         next_reg_hit = 1'b0;
      end
   end

   // readback register, loaded every cycle from the current address
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= '0;
         reg_hit   <= 1'b0;
      end else begin
         reg_rdata <= next_reg_rdata;
         reg_hit   <= next_reg_hit;
      end
   end
endmodule
`default_nettype wire

// File: nlcr_config_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// ties register writes to the bank's decoded outputs
module nlcr_config_regs_props (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        reg_wr,
   input wire logic [6:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_hit,
   input wire logic        filt1_commit,
   input wire logic        filt3_commit,
   input wire logic [13:0] filt1_coef_first,
   input wire logic        filt1_on,
   input wire logic        filt3_lowpass_sel,
   input wire logic        peak_limiter_on,
   input wire logic [3:0]  peak_limiter_release,
   input wire logic [16:0] release_step_samples
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire w12 = reg_wr && reg_addr == 7'h12;                   // filter 1 first register write
   wire w17 = reg_wr && reg_addr == 7'h17;                   // filter 3 second register write
   wire in_bank = reg_addr >= 7'h10 && reg_addr <= 7'h19;    // address in this bank
   property p_commit_first; w12 && reg_wdata[15] |=> filt1_commit && filt1_coef_first == $past(reg_wdata[13:0]); endproperty
   a_commit_first: assert property (p_commit_first) else $error("commit load wrong");
   property p_commit_second; w17 && reg_wdata[15] |=> filt3_commit; endproperty
   a_commit_second: assert property (p_commit_second) else $error("second commit lost");
   property p_hold; !filt1_commit |-> $stable(filt1_coef_first); endproperty
   a_hold: assert property (p_hold) else $error("coef moved without commit");
   property p_on; w12 |=> filt1_on == $past(reg_wdata[14]); endproperty
   a_on: assert property (p_on) else $error("enable wrong");
   property p_lp; w17 |=> filt3_lowpass_sel == $past(reg_wdata[14]); endproperty
   a_lp: assert property (p_lp) else $error("mode wrong");
   property p_lim; reg_wr && reg_addr == 7'h18 |=> peak_limiter_on == $past(reg_wdata[8]); endproperty
   a_lim: assert property (p_lim) else $error("limiter enable wrong");
   property p_release; $stable(peak_limiter_release)[*2] |-> release_step_samples ==
      (17'd33 << (peak_limiter_release > 4'hb ? 4'hb : peak_limiter_release)); endproperty
   a_release: assert property (p_release) else $error("release step wrong");
   property p_read; 1 |=> reg_hit == $past(in_bank) && (reg_hit || reg_rdata == 16'h0000); endproperty
   a_read: assert property (p_read) else $error("readback hit wrong");
   c_commit: cover property (w17 && reg_wdata[15]);
   c_lp: cover property (w17 && reg_wdata[14]);
   c_miss: cover property (reg_wr && !in_bank);
endmodule
bind nlcr_config_regs nlcr_config_regs_props u_props (.clk(clk), .reset(reset), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
   .filt1_commit(filt1_commit), .filt3_commit(filt3_commit), .filt1_coef_first(filt1_coef_first),
   .filt1_on(filt1_on), .filt3_lowpass_sel(filt3_lowpass_sel), .peak_limiter_on(peak_limiter_on),
   .peak_limiter_release(peak_limiter_release), .release_step_samples(release_step_samples));
`default_nettype wire

// File: nlcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the control port: one write or read at a time
module nlcr_host (
   input  wire logic        clk,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_hit,
   output logic             reg_wr,
   output logic [6:0]       reg_addr,
   output logic [15:0]      reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 16'h0000;
   end
   // one-cycle strobe; data inverted after, so stale values show
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // read data arrives a cycle after the address
   task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic h);
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      #1;
      d = reg_rdata;
      h = reg_hit;
   endtask
endmodule
`default_nettype wire

// File: notch_limiter_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
// random and swept register traffic against a model
module notch_limiter_config_regs_tb;
   logic        clk, reset, reg_wr, reg_hit, hit;
   logic [6:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd_d;
   logic [13:0] filt0_coef_first, filt0_coef_second, filt1_coef_first, filt1_coef_second;
   logic [13:0] filt2_coef_first, filt2_coef_second, filt3_coef_first, filt3_coef_second;
   logic        filt0_on, filt1_on, filt2_on, filt3_on, filt3_lowpass_sel, peak_limiter_on;
   logic        filt0_commit, filt1_commit, filt2_commit, filt3_commit;
   logic [3:0]  peak_limiter_release, peak_limiter_attack, peak_limiter_gain_lift, gain_lift_db;
   logic [16:0] release_step_samples, attack_step_samples;
   logic [2:0]  peak_limiter_threshold, threshold_db_below;
   logic [15:0] img [16:25];   // stored register bits
   logic [13:0] wk [8];        // working coefficients
   logic [3:0]  cm;            // expected commit pulses
   logic [31:0] seed;          // xorshift state
   int          failures, compares, cyc;
   nlcr_config_regs dut_u (.clk, .reset, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
      .filt0_coef_first, .filt0_coef_second, .filt0_on, .filt0_commit, .filt1_coef_first,
      .filt1_coef_second, .filt1_on, .filt1_commit, .filt2_coef_first, .filt2_coef_second,
      .filt2_on, .filt2_commit, .filt3_coef_first, .filt3_coef_second, .filt3_on, .filt3_commit,
      .filt3_lowpass_sel, .peak_limiter_on, .peak_limiter_release, .peak_limiter_attack,
      .release_step_samples, .attack_step_samples, .peak_limiter_threshold, .threshold_db_below,
      .peak_limiter_gain_lift, .gain_lift_db);
   nlcr_host host_u (.clk, .reg_rdata, .reg_hit, .reg_wr, .reg_addr, .reg_wdata);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // mask of stored bits per register
   function automatic logic [15:0] msk(input int a);
      case (a)
         16, 18, 20, 22, 23: return 16'h7fff;
         24: return 16'h01ff;
         25: return 16'h007f;
         default: return 16'h3fff;
      endcase
   endfunction
   // xorshift step
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(input logic [127:0] g, input logic [127:0] e, input string m);
      compares++;
      if (g !== e) begin
         failures++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // write via host, update model, compare all fields
   task automatic mwr(input int a, input logic [15:0] d);
      int f;
      f = (a - 16) / 2;
      cm = 4'h0;
      if (a >= 16 && a <= 25) img[a] = d & msk(a);
      if (a >= 16 && a <= 23 && d[15]) begin
         wk[2*f] = img[16+2*f][13:0];
         wk[2*f+1] = img[17+2*f][13:0];
         cm[f] = 1'b1;
      end
      host_u.wr(a[6:0], d);
      #1;
      chk({filt3_commit, filt2_commit, filt1_commit, filt0_commit}, cm, "commit");
      chk({filt0_coef_first, filt0_coef_second, filt1_coef_first, filt1_coef_second,
         filt2_coef_first, filt2_coef_second, filt3_coef_first, filt3_coef_second},
         {wk[0], wk[1], wk[2], wk[3], wk[4], wk[5], wk[6], wk[7]}, "coef");
      chk({filt3_on, filt2_on, filt1_on, filt0_on, filt3_lowpass_sel, peak_limiter_on},
         {img[22][14], img[20][14], img[18][14], img[16][14], img[23][14], img[24][8]},
         "ctrl");
      chk({peak_limiter_release, peak_limiter_attack, peak_limiter_threshold,
         peak_limiter_gain_lift}, {img[24][7:0], img[25][6:0]}, "fields");
   endtask
   task automatic mrd(input int a);
      host_u.rd(a[6:0], rd_d, hit);
      chk({hit, rd_d}, (a >= 16 && a <= 25) ? {1'b1, img[a]} : 17'h0, "read");
   endtask
   task automatic end_of_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // hang guard, far above the ~450-cycle run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         end_of_test;
      end
   end
   initial begin
      seed = 32'hf477;
      cyc = 0;
      reset = 1'b1;
      for (int a = 16; a <= 25; a++) img[a] = (a == 24) ? 16'h0032 : 16'h0000;
      for (int k = 0; k < 8; k++) wk[k] = 14'h0000;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      for (int a = 15; a <= 26; a++) mrd(a);
      for (int i = 0; i < 16; i++) begin
         mwr(24, {7'h00, i[0], i[3:0], i[3:0]});
         mwr(25, {9'h000, i[2:0], i[3:0]});
         repeat (2) @(posedge clk);
         #1;
         chk(release_step_samples, 17'd33 << (i > 11 ? 11 : i), "release");
         chk(attack_step_samples, 17'd4 << (i > 11 ? 11 : i), "attack");
         chk(threshold_db_below, (i % 8 > 4) ? 6 : i % 8 + 1, "threshold");
         chk(gain_lift_db, i > 12 ? 12 : i, "lift");
      end
      repeat (80) begin
         seed = xs(seed);
         mwr(15 + seed[31:28] % 12, seed[15:0]);
         mrd(15 + seed[27:24] % 12);
      end
      end_of_test;
   end
endmodule
`default_nettype wire
